/* alz_pkg.sv */
// Purpose: Shared constants for the angle linearizer.
// Assumes: 16-bit angle words, one full turn equals 2**16 counts.
// Notes: Register offsets are word indices on the plain register port.
package alz_pkg;
  localparam int ANG_W = 16;
  localparam int COEF_W = 12;
  localparam int NUM_BP = 32;
  localparam int IDX_W = 5;
  localparam int FRAC_W = ANG_W - IDX_W;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;
  // Register word indices.
  localparam logic [5:0] OFS_COEF0 = 6'h00;
  localparam logic [5:0] OFS_CTRL = 6'h20;
  localparam logic [5:0] OFS_WAKE_THR = 6'h21;
  localparam logic [5:0] OFS_STATUS = 6'h22;
  // Control register field positions.
  localparam int CTRL_LIN_EN = 0;
  localparam int CTRL_SCALE = 1;
  localparam int CTRL_LP_REQ = 2;
  // Status register field positions.
  localparam int STAT_LP = 0;
  localparam int STAT_FAST = 1;
  localparam int STAT_ANG_LSB = 16;
  // Values after reset.
  localparam logic [COEF_W-1:0] COEF_RST = 12'h000;
  localparam logic LIN_EN_RST = 1'b0;
  localparam logic SCALE_RST = 1'b0;
  // Coefficient weight in angle counts: 2 counts per LSB at 22.5 deg, 4 at 45 deg.
  localparam int SHIFT_NARROW = 1;
  localparam int SHIFT_WIDE = 2;
  // Latency of the angle path, in clock cycles.
  localparam int PATH_LAT = 3;
  // Wake-up detection timing.
  localparam longint CLK_HZ = 100_000_000;
  localparam longint WAKE_WIN_US = 1000;
  localparam longint WAKE_WIN_CYC = WAKE_WIN_US * CLK_HZ / 1_000_000;
  localparam longint WAKE_RPM = 100;
  localparam longint WAKE_THR_CNT =
    WAKE_RPM * (longint'(1) << ANG_W) * WAKE_WIN_US / 60_000_000;
  localparam logic [ANG_W-1:0] WAKE_THR_RST = ANG_W'(WAKE_THR_CNT);
endpackage : alz_pkg

/* alz_wake_det.sv */
// Purpose: Measures the raw angle change per window and flags fast rotation.
// Assumes: Angle samples come from logic on the same clock.
// Notes: Change is taken modulo one turn, so wrap at zero is handled.
`timescale 1ns/100ps
`default_nettype none
module alz_wake_det
  import alz_pkg::*;
#(
  parameter int WIN_CYC = 100000
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Raw angle stream.
  input wire logic [ANG_W-1:0] raw_angle,
  input wire logic raw_valid,
  // Threshold and result.
  input wire logic [ANG_W-1:0] thr,
  output logic fast
);
  logic [31:0] win_cnt_r;
  logic [ANG_W-1:0] last_r;
  logic [ANG_W-1:0] prev_r;
  logic fast_r;
  wire win_end = (win_cnt_r == 32'(WIN_CYC - 1));
  wire [ANG_W-1:0] delta = last_r - prev_r;
  wire [ANG_W-1:0] mag = delta[ANG_W-1] ? ANG_W'(-delta) : delta;

  // Keeps the latest unlinearized sample and compares it once per window.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_r <= 32'h0000_0000;
      last_r <= 16'h0000;
      prev_r <= 16'h0000;
      fast_r <= 1'b0;
    end else begin
      if (raw_valid) begin
        last_r <= raw_angle;
      end
      win_cnt_r <= win_end ? 32'h0000_0000 : win_cnt_r + 32'h0000_0001;
      if (win_end) begin
        prev_r <= last_r;
        fast_r <= (mag > thr);
      end
    end
  end

  assign fast = fast_r;

  raw_track_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    raw_valid |=> last_r == $past(raw_angle))
    else $error("wake path does not follow the raw angle");
endmodule : alz_wake_det
`default_nettype wire

/* alz_angle_linearizer.sv */
// Purpose: Piecewise-linear angle correction with low-power wake decision.
// Assumes: One clock; coefficients loaded by software after reset.
// Notes: Output follows input by three cycles, linearized or not.
// Function
// - Hold 32 coefficients at 11.25 degree breakpoints.
// - At breakpoint, output is angle minus coefficient.
// - Coefficients are 12-bit two's-complement values.
// - Scale select picks 22.5 or 45 degree range.
// - Between breakpoints, interpolate neighbouring coefficients linearly.
// - Latency identical with linearization on or off.
// - Disabled linearization passes the angle unchanged.
// - Low-power mode wakes above programmable change rate.
// - Default setting stays awake above 100 rpm.
// - Wake detection uses the unlinearized angle.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module alz_angle_linearizer
  import alz_pkg::*;
#(
  parameter int WIN_CYC = int'(WAKE_WIN_CYC)
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Electrical angle from the upstream datapath.
  input wire logic [ANG_W-1:0] angle_in,
  input wire logic angle_in_valid,
  // Corrected angle to the output encoders.
  output logic [ANG_W-1:0] angle_out,
  output logic angle_out_valid,
  // Power state.
  output logic low_power
);
  // Coefficient store and control state.
  logic [COEF_W-1:0] coef_r [NUM_BP];
  logic lin_en_r;
  logic correction_scale_select_r;
  logic [ANG_W-1:0] wake_thr_r;
  logic lp_r;
  logic [DATA_W-1:0] rdata_r;
  // Pipeline registers.
  logic v1_r, v2_r, v3_r;
  logic en1_r, en2_r, sc1_r;
  logic [ANG_W-1:0] a1_r, a2_r, out_r;
  logic signed [COEF_W-1:0] c0_r, c1_r;
  logic [FRAC_W-1:0] frac_r;
  logic signed [ANG_W-1:0] corr_r;
  logic fast;

  // Address decode.
  // Coefficient words share the low index bits with the store address.
  wire is_coef = (reg_addr < 6'(NUM_BP));
  wire is_ctrl = (reg_addr == OFS_CTRL);
  wire is_thr = (reg_addr == OFS_WAKE_THR);
  wire is_stat = (reg_addr == OFS_STATUS);
  wire [IDX_W-1:0] wr_idx = reg_addr[IDX_W-1:0];

  // Breakpoint selection: upper bits pick the segment, the rest the position.
  wire [IDX_W-1:0] idx = angle_in[ANG_W-1:FRAC_W];
  wire [IDX_W-1:0] idx_nxt = idx + 5'h01;
  wire [FRAC_W-1:0] frac = angle_in[FRAC_W-1:0];

  // Interpolation between the two neighbouring coefficients.
  // The signed difference of two 12-bit values needs one extra bit.
  // The product is shifted arithmetically, so rounding is toward minus infinity.
  wire signed [COEF_W:0] diff = {c1_r[COEF_W-1], c1_r} - {c0_r[COEF_W-1], c0_r};
  wire signed [COEF_W+FRAC_W+1:0] prod = diff * $signed({1'b0, frac_r});
  wire signed [COEF_W+FRAC_W+1:0] prod_sh = prod >>> FRAC_W;
  wire signed [COEF_W:0] interp = {c0_r[COEF_W-1], c0_r} + prod_sh[COEF_W:0];
  wire signed [ANG_W-1:0] interp_ext = ANG_W'(interp);
  wire signed [ANG_W-1:0] corr_nxt = sc1_r ? (interp_ext <<< SHIFT_WIDE)
                                           : (interp_ext <<< SHIFT_NARROW);
  wire [ANG_W-1:0] out_nxt = en2_r ? (a2_r - corr_r) : a2_r;

  // Read multiplexer.
  // Unmapped indices read as zero, and the status word is read only.
  wire [DATA_W-1:0] stat_word = {out_r, 14'h0000, fast, lp_r};
  wire [DATA_W-1:0] ctrl_word = {29'h0000_0000, lp_r, correction_scale_select_r, lin_en_r};
  wire [DATA_W-1:0] coef_word = {{(DATA_W-COEF_W){coef_r[wr_idx][COEF_W-1]}}, coef_r[wr_idx]};
  wire [DATA_W-1:0] rd_mux = is_coef ? coef_word :
                             is_ctrl ? ctrl_word :
                             is_thr ? {16'h0000, wake_thr_r} :
                             is_stat ? stat_word : 32'h0000_0000;

  // Low-power entry and exit.
  // A wake and a request in one cycle resolve to staying awake.
  wire lp_enter = reg_wr && is_ctrl && reg_wdata[CTRL_LP_REQ] && !fast;
  wire lp_wake = lp_r && fast;

  // Coefficient store, written one word at a time.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_BP; i++) begin
        coef_r[i] <= COEF_RST;
      end
    end else if (reg_wr && is_coef) begin
      coef_r[wr_idx] <= reg_wdata[COEF_W-1:0];
    end
  end

  // Control registers and power state.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lin_en_r <= LIN_EN_RST;
      correction_scale_select_r <= SCALE_RST;
      wake_thr_r <= WAKE_THR_RST;
      lp_r <= 1'b0;
    end else begin
      if (reg_wr && is_ctrl) begin
        lin_en_r <= reg_wdata[CTRL_LIN_EN];
        correction_scale_select_r <= reg_wdata[CTRL_SCALE];
      end
      if (reg_wr && is_thr) begin
        wake_thr_r <= reg_wdata[ANG_W-1:0];
      end
      if (lp_wake) begin
        lp_r <= 1'b0;
      end else if (lp_enter) begin
        lp_r <= 1'b1;
      end
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Stage 1: capture angle and the two neighbouring coefficients.
  // Enable and scale are taken on the same edge, so a control write that lands
  // between samples never splits one sample across two settings.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      v1_r <= 1'b0;
      en1_r <= 1'b0;
      sc1_r <= 1'b0;
      a1_r <= 16'h0000;
      c0_r <= 12'h000;
      c1_r <= 12'h000;
      frac_r <= 11'h000;
    end else begin
      v1_r <= angle_in_valid;
      en1_r <= lin_en_r;
      sc1_r <= correction_scale_select_r;
      a1_r <= angle_in;
      c0_r <= coef_r[idx];
      c1_r <= coef_r[idx_nxt];
      frac_r <= frac;
    end
  end

  // Stage 2: scaled correction; the same stages run when disabled.
  // Running both branches keeps the delay the same with correction off.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      v2_r <= 1'b0;
      en2_r <= 1'b0;
      a2_r <= 16'h0000;
      corr_r <= 16'h0000;
    end else begin
      v2_r <= v1_r;
      en2_r <= en1_r;
      a2_r <= a1_r;
      corr_r <= corr_nxt;
    end
  end

  // Stage 3: subtract the correction or pass the angle through.
  // The output holds between samples so the encoders always see a settled word.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      v3_r <= 1'b0;
      out_r <= 16'h0000;
    end else begin
      v3_r <= v2_r;
      if (v2_r) begin
        out_r <= out_nxt;
      end
    end
  end

  // Wake detection fed with the raw electrical angle.
  // The threshold comes from a register so the wake rate can be tuned.
  alz_wake_det #(
    .WIN_CYC(WIN_CYC)
  ) u_wake (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .raw_angle(angle_in),
    .raw_valid(angle_in_valid),
    .thr(wake_thr_r),
    .fast(fast)
  );

  assign reg_rdata = rdata_r;
  assign angle_out = out_r;
  assign angle_out_valid = v3_r;
  assign low_power = lp_r;

  // Checks kept next to the datapath.
  same_latency_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    angle_in_valid |-> ##3 angle_out_valid)
    else $error("angle path latency is not three cycles");

  bypass_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (angle_in_valid && !lin_en_r) |-> ##3 (angle_out == $past(angle_in, 3)))
    else $error("disabled path altered the angle");

  breakpoint_sub_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (v1_r && frac_r == 11'h000) |=>
      corr_r == ($past(sc1_r) ? ($past(ANG_W'(c0_r)) <<< SHIFT_WIDE)
                       : ($past(ANG_W'(c0_r)) <<< SHIFT_NARROW)))
    else $error("breakpoint correction differs from its coefficient");

  midpoint_avg_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (frac_r == 11'h400) |-> (interp == ((13'(c0_r) + 13'(c1_r)) >>> 1)))
    else $error("midpoint correction is not the average");

  scale_weight_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sc1_r |-> (corr_nxt == (interp_ext * 16'sd4)))
    else $error("wide scale weight is not four counts per step");

  coef_sign_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (interp_ext[ANG_W-1] == interp[COEF_W]) && (interp <= 13'sd2047)
      && (interp >= -13'sd2048))
    else $error("correction left the signed coefficient range");

  coef_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && is_coef) |=> coef_r[$past(wr_idx)] == $past(reg_wdata[COEF_W-1:0]))
    else $error("coefficient write not stored");

  seg_wrap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (idx == 5'h1F) |=> (c1_r == $past(coef_r[0])))
    else $error("last segment does not use the first coefficient");

  wake_exit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (lp_r && fast) |=> !lp_r)
    else $error("low-power mode not left on fast rotation");

  stay_awake_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!lp_r && fast) |=> !lp_r)
    else $error("entered low power while rotating fast");

  // Breakpoint output at narrow scale, reckoned from the input edge alone.
  bp_narrow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (angle_in_valid && lin_en_r && !correction_scale_select_r && frac == 11'h000) |->
      ##3 (angle_out == $past(angle_in - (ANG_W'($signed(coef_r[idx])) <<< SHIFT_NARROW), 3)))
    else $error("narrow breakpoint output differs from angle minus coefficient");

  // Breakpoint output at wide scale, four counts per coefficient step.
  bp_wide_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (angle_in_valid && lin_en_r && correction_scale_select_r && frac == 11'h000) |->
      ##3 (angle_out == $past(angle_in - (ANG_W'($signed(coef_r[idx])) <<< SHIFT_WIDE), 3)))
    else $error("wide breakpoint output differs from angle minus coefficient");

  // One result per sample: no input, no output three cycles on.
  valid_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !angle_in_valid |-> ##3 !angle_out_valid)
    else $error("angle output valid without a sample");

  // The corrected angle holds between results.
  out_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !v2_r |=> $stable(angle_out))
    else $error("angle output changed without a result");

  // Read data stands only in the cycle after a read strobe.
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !reg_rd |=> (reg_rdata == 32'h0000_0000))
    else $error("read data present without a read");

  // Coefficient read-back carries the sign of the stored word.
  coef_sext_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_rd && is_coef) |=>
      ((&reg_rdata[DATA_W-1:COEF_W-1]) || !(|reg_rdata[DATA_W-1:COEF_W-1])))
    else $error("coefficient read-back is not sign-extended");

  // A request with slow rotation enters low power on the next edge.
  lp_enter_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && is_ctrl && reg_wdata[CTRL_LP_REQ] && !fast) |=> lp_r)
    else $error("low-power request with slow rotation was not taken");

  // The wake threshold takes the written value.
  thr_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && is_thr) |=> (wake_thr_r == $past(reg_wdata[ANG_W-1:0])))
    else $error("wake threshold write not stored");

  // Scale select takes its control bit.
  scale_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && is_ctrl) |=> (correction_scale_select_r == $past(reg_wdata[CTRL_SCALE])))
    else $error("scale select write not stored");

  // Linearization enable takes its control bit.
  lin_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reg_wr && is_ctrl) |=> (lin_en_r == $past(reg_wdata[CTRL_LIN_EN])))
    else $error("linearization enable write not stored");
endmodule : alz_angle_linearizer
`default_nettype wire

/* alz_angle_src.sv */
// Purpose: Model of the upstream angle datapath feeding raw angles.
// Assumes: Samples launch right after a rising edge of sys_clk.
// Notes: Outside samples the angle bus shows the inverted last value.
`timescale 1ns/100ps
`default_nettype none
module alz_angle_src
  import alz_pkg::*;
(
  // Clock.
  input wire logic sys_clk,
  // Angle stream toward the block.
  output var logic [ANG_W-1:0] angle,
  output var logic valid
);
  // Idle values at time zero.
  initial begin
    angle = '0;
    valid = 1'b0;
  end

  // Sends one sample, then scrambles the bus so stale data cannot pass.
  task automatic send(input logic [ANG_W-1:0] a);
    @(posedge sys_clk);
    angle <= a;
    valid <= 1'b1;
    @(posedge sys_clk);
    angle <= ~a;
    valid <= 1'b0;
  endtask : send

  // Streams a turning angle, one sample per cycle, step counts apart.
  task automatic spin(input logic [ANG_W-1:0] start, input logic [ANG_W-1:0] step,
                      input int n);
    @(posedge sys_clk);
    angle <= start;
    valid <= 1'b1;
    repeat (n) begin
      @(posedge sys_clk);
      angle <= angle + step;
    end
    @(posedge sys_clk);
    valid <= 1'b0;
    angle <= ~angle;
  endtask : spin
endmodule : alz_angle_src
`default_nettype wire

/* alz_angle_linearizer_tb.sv */
// Purpose: Self-checking bench for the angle linearizer.
// Assumes: A 64-cycle wake window keeps the power tests short.
// Notes: Raw angles come from the source model instance src.
`timescale 1ns/100ps
`default_nettype none
module alz_angle_linearizer_tb
  import alz_pkg::*;
;
  localparam int WIN = 64;
  logic sys_clk, rst_n, reg_wr, reg_rd, ain_v, aout_v, low_power, lin_m, scl_m;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic [ANG_W-1:0] ain, aout;
  int err_total, check_count, cf[NUM_BP];

  // Design and its upstream source.
  alz_angle_linearizer #(.WIN_CYC(WIN)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .angle_in(ain), .angle_in_valid(ain_v), .angle_out(aout),
    .angle_out_valid(aout_v), .low_power(low_power));
  alz_angle_src src (.sys_clk(sys_clk), .angle(ain), .valid(ain_v));

  // Free-running 100 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data is taken in the single cycle after the read edge.
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic set_cf(input int k, input int v);
    cf[k] = v;
    wr(ADDR_W'(k), DATA_W'(v & 32'hFFF));
  endtask : set_cf

  // Interpolated correction with floor rounding, wrapped to one turn.
  function automatic logic [ANG_W-1:0] exp_out(input logic [ANG_W-1:0] a);
    int i, f, c;
    i = int'(a[15:11]);
    f = int'(a[10:0]);
    c = cf[i] + (((cf[(i + 1) % NUM_BP] - cf[i]) * f) >>> 11);
    if (!lin_m) return a;
    return a - ANG_W'(c <<< (scl_m ? SHIFT_WIDE : SHIFT_NARROW));
  endfunction : exp_out

  task automatic ang_chk(input logic [ANG_W-1:0] a);
    logic [ANG_W-1:0] e;
    e = exp_out(a);
    src.send(a);
    @(posedge sys_clk);
    #1 chk("early valid", 0, aout_v);
    @(posedge sys_clk);
    #1 chk("valid", 1, aout_v);
    chk("angle_out", e, aout);
  endtask : ang_chk

  task automatic t_regs();
    rd(OFS_CTRL);
    chk("ctrl reset", 0, d);
    rd(OFS_WAKE_THR);
    chk("threshold reset", DATA_W'(WAKE_THR_RST), d);
    @(posedge sys_clk);
    #1 chk("read data after its cycle", 0, reg_rdata);
    for (int k = 0; k < NUM_BP; k++) begin
      set_cf(k, (k == 31) ? -2048 : 2047 - k * 131);
    end
    for (int k = 0; k < NUM_BP; k++) begin
      rd(ADDR_W'(k));
      chk("coefficient", DATA_W'(cf[k]), d);
    end
    wr(6'h23, 32'hFFFF_FFFF);
    rd(6'h23);
    chk("unmapped", 0, d);
    $display("register test done");
  endtask : t_regs

  task automatic t_path(input logic lin, input logic scl);
    logic [ANG_W-1:0] al[7] = '{16'h0000, 16'h2800, 16'hF800, 16'h1C00, 16'hFC00,
                                16'h2A5B, 16'h0010};
    lin_m = lin;
    scl_m = scl;
    wr(OFS_CTRL, DATA_W'({scl, lin}));
    foreach (al[i]) ang_chk(al[i]);
    rd(OFS_STATUS);
    chk("status angle", DATA_W'(exp_out(16'h0010)), d >> STAT_ANG_LSB);
    $display("path test lin=%0d scale=%0d done", lin, scl);
  endtask : t_path

  // Steep coefficients make the corrected angle fast while the raw one is slow.
  task automatic t_power();
    set_cf(4, 2047);
    set_cf(5, -2048);
    src.send(16'h2000);
    repeat (3 * WIN) @(posedge sys_clk);
    wr(OFS_CTRL, 32'h7);
    @(posedge sys_clk);
    #1 chk("low power entry", 1, low_power);
    rd(OFS_CTRL);
    chk("ctrl with low power", 32'h0000_0007, d);
    rd(OFS_STATUS);
    chk("status flags", 32'h0000_0001, d & 32'h0000_0003);
    src.spin(16'h2000, 16'h0001, 3 * WIN);
    #1 chk("slow raw turn", 1, low_power);
    fork
      src.spin(16'h2000, 16'h0002, 3 * WIN);
      begin
        repeat (2 * WIN + 8) @(posedge sys_clk);
        wr(OFS_CTRL, 32'h7);
        @(posedge sys_clk);
        #1 chk("woken and refused", 0, low_power);
      end
    join
    src.send(16'h2000);
    repeat (3 * WIN) @(posedge sys_clk);
    wr(OFS_WAKE_THR, 32'h0000_00C8);
    rd(OFS_WAKE_THR);
    chk("threshold", 32'h0000_00C8, d);
    wr(OFS_CTRL, 32'h7);
    src.spin(16'h2000, 16'h0002, 3 * WIN);
    #1 chk("under threshold", 1, low_power);
    src.spin(16'h2180, 16'h0004, 3 * WIN);
    #1 chk("over threshold", 0, low_power);
    $display("power test done");
  endtask : t_power

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // Main sequence after a five-cycle reset.
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    err_total = 0;
    check_count = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_path(1'b0, 1'b0);
    t_path(1'b1, 1'b0);
    t_path(1'b1, 1'b1);
    t_power();
    close_out();
  end

  // Watchdog cuts a hang well beyond the roughly 1,400 cycles expected.
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    close_out();
  end
endmodule : alz_angle_linearizer_tb
`default_nettype wire
